// ### msi_pkg.sv
// Constants, encodings and carrier types for the event flag block
package msi_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned PORTS   = 12;
    localparam int unsigned GROUPS  = 3;
    localparam int unsigned TEMP_W  = 12;
    localparam int unsigned AVG_W   = 3;
    localparam int unsigned CNT_W   = 7;

    // ************************************************************
    // Register read addresses
    // ************************************************************
    localparam logic [7:0] ADDR_IDENTITY    = 8'h00;
    localparam logic [7:0] ADDR_EVENT       = 8'h01;
    localparam logic [7:0] ADDR_STATUS_BASE = 8'h02;

    // ************************************************************
    // Values
    // ************************************************************
    // Identity value is arbitrary
    localparam logic [15:0] DEVICE_IDENTITY_CODE = 16'h5A3C;
    localparam logic [15:0] READ_IDLE            = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RESET       = 7'h00;

    // ************************************************************
    // Event register field positions
    // ************************************************************
    localparam int unsigned BIT_ADC_GENERAL = 0;
    localparam int unsigned BIT_ADC_READY   = 1;
    localparam int unsigned BIT_ADC_OVERRUN = 2;
    localparam int unsigned BIT_IN_EVENT    = 3;
    localparam int unsigned BIT_IN_OVERRUN  = 4;
    localparam int unsigned BIT_OVERCURRENT = 5;
    localparam int unsigned BIT_TEMP_INT    = 6;
    localparam int unsigned BIT_TEMP_REM1   = 9;
    localparam int unsigned BIT_TEMP_REM2   = 12;
    localparam int unsigned BIT_SUPPLY_LOW  = 15;
    localparam int unsigned TF_NEW          = 0;
    localparam int unsigned TF_LOW          = 1;
    localparam int unsigned TF_HIGH         = 2;
    localparam int unsigned STATUS_LO_W     = 11;
    localparam int unsigned STATUS_HI_BIT   = 11;

    // Groups whose flags need the two status reads
    localparam int unsigned GRP_ADC = 0;
    localparam int unsigned GRP_IN  = 1;
    localparam int unsigned GRP_OC  = 2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MSI_ADC_SINGLE_CONV,
        MSI_ADC_SINGLE_SWEEP,
        MSI_ADC_CONT_SWEEP,
        MSI_ADC_IDLE
    } msi_adc_mode_t;

    typedef enum logic [1:0] {
        MSI_IN_NONE,
        MSI_IN_RISE,
        MSI_IN_FALL,
        MSI_IN_BOTH
    } msi_in_mode_t;

    typedef enum logic {
        MSI_CLR_IDLE,
        MSI_CLR_ARMED
    } msi_clr_state_t;

    typedef struct packed {
        logic              valid;
        logic [TEMP_W-1:0] value;
        logic [TEMP_W-1:0] high_limit;
        logic [TEMP_W-1:0] low_limit;
    } msi_temp_t;

endpackage

// ### msi_temp_flags.sv
// Three sticky temperature flags for one sensor
`timescale 1ns/1ps
module msi_temp_flags
    import msi_pkg::*;
(
    input  wire logic      i_ref_clk,   // System clock
    input  wire logic      i_reset_n,   // Async reset, active low
    input  wire msi_temp_t i_temp,      // New reading and limits
    input  wire logic      i_clear,     // Event register read
    output logic [2:0]     o_flags      // High, low, new
);

    logic [2:0] set;
    logic [2:0] flags_d;
    logic [2:0] flags_q;

    // Readings and limits are two's complement
    assign set[TF_HIGH] = i_temp.valid
                        & ($signed(i_temp.value)
                           > $signed(i_temp.high_limit));
    assign set[TF_LOW]  = i_temp.valid
                        & ($signed(i_temp.value)
                           < $signed(i_temp.low_limit));
    assign set[TF_NEW]  = i_temp.valid;
    // Set wins over the read clear [R12] [R13] [R14]
    assign flags_d      = set | (flags_q & ~{3{i_clear}});
    assign o_flags      = flags_q;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags_q <= 3'h0;
        end else begin
            flags_q <= flags_d;
        end
    end

    property p_temp_high;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        set[TF_HIGH] |=> o_flags[TF_HIGH] && o_flags[TF_NEW];
    endproperty
    a_temp_high: assert property (p_temp_high) // [R12]
        else $error("high temperature flag not raised");

endmodule

// ### msi_event_flags.sv
// Event register, identity register and clear sequencing
// Behaviour
// [R1] Identity register is read only and returns a fixed 16-bit code.
// [R2] Any ADC data register refresh sets the ready flag, bit 1.
// [R3] Averaging port refreshes only after its power-of-two count of sweeps; in single conversion mode the code counts conversions.
// [R4] Refresh per conversion in single mode, per sweep in sweep modes.
// [R5] Ready flag clears after event read then both ADC status reads.
// [R6] Overwrite of unread ADC data sets bit 2; event read clears it.
// [R7] Input event of the selected type on a port sets bit 3.
// [R8] Bits 3 and 4 clear after event read then both input status reads.
// [R9] Input status overwritten before being read sets bit 4.
// [R10] Any output driver overcurrent sets bit 5; ports show in status.
// [R11] Bit 5 clears after event read then both overcurrent status reads.
// [R12] Bits 8:6 internal sensor: above high, below low, new; read clears.
// [R13] Bits 11:9 first remote sensor, same layout; read clears.
// [R14] Bits 14:12 second remote sensor, same layout; read clears.
// [R15] Supply below about 4V sets bit 15; event read clears it.
// [R16] Port status capture never depends on any interrupt mask.
// [R17] Bit 0 general ADC flag set by event, cleared by event read.
`timescale 1ns/1ps
module msi_event_flags
    import msi_pkg::*;
(
    input  wire logic               i_ref_clk,        // System clock
    input  wire logic               i_reset_n,        // Async reset, low
    input  wire logic               i_rd_en,          // Register read
    input  wire logic [7:0]         i_rd_addr,        // Read address
    output logic [15:0]             o_rd_data,        // Read data
    output logic                    o_rd_valid,       // Read data strobe
    input  wire msi_adc_mode_t      i_adc_mode,       // Conversion mode
    input  wire logic [PORTS-1:0]   i_adc_conv_done,  // Conversion ended
    input  wire logic               i_adc_sweep_done, // Sweep ended
    input  wire logic [PORTS*AVG_W-1:0] i_adc_avg_log2, // Averaging N
    input  wire logic [PORTS-1:0]   i_adc_data_read,  // Data reg read
    input  wire logic               i_adc_flag_event, // General ADC event
    output logic [PORTS-1:0]        o_adc_refresh,    // Load data reg
    input  wire logic [PORTS-1:0]   i_in_pin,         // Input port pins
    input  wire logic [PORTS*2-1:0] i_in_mode,        // Edge selection
    input  wire logic [PORTS-1:0]   i_oc_pin,         // Overcurrent pins
    input  wire logic               i_supply_low_pin, // Supply monitor
    input  wire msi_temp_t          i_temp_int,       // Internal sensor
    input  wire msi_temp_t          i_temp_rem1,      // Remote sensor 1
    input  wire msi_temp_t          i_temp_rem2       // Remote sensor 2
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int unsigned SYNC_W = 2 * PORTS + 1;

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [PORTS-1:0]  in_s;
    logic [PORTS-1:0]  in_prev_q;
    logic [PORTS-1:0]  oc_s;
    logic              supply_low_s;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {i_supply_low_pin, i_oc_pin, i_in_pin};
            sync2_q <= sync1_q;
        end
    end

    assign in_s         = sync2_q[PORTS-1:0];
    assign oc_s         = sync2_q[2*PORTS-1:PORTS];
    assign supply_low_s = sync2_q[2*PORTS];

    // ************************************************************
    // Read decode
    // ************************************************************
    logic              rd_id;
    logic              rd_event;
    logic [GROUPS-1:0] rd_lo;
    logic [GROUPS-1:0] rd_hi;
    logic [GROUPS-1:0] grp_done;
    logic [PORTS-1:0]  grp_status [GROUPS];

    assign rd_id    = i_rd_en & (i_rd_addr == ADDR_IDENTITY);
    assign rd_event = i_rd_en & (i_rd_addr == ADDR_EVENT);

    // ************************************************************
    // Clear sequence: event read, then both status halves
    // ************************************************************
    for (genvar g = 0; g < GROUPS; g++) begin : g_clr
        localparam logic [7:0] LO_ADDR = 8'(ADDR_STATUS_BASE + 2 * g);
        localparam logic [7:0] HI_ADDR = 8'(ADDR_STATUS_BASE + 2 * g + 1);

        msi_clr_state_t state_q;
        msi_clr_state_t state_d;
        logic           seen_lo_q;
        logic           seen_hi_q;
        logic           lo_ok;
        logic           hi_ok;

        assign rd_lo[g]    = i_rd_en & (i_rd_addr == LO_ADDR);
        assign rd_hi[g]    = i_rd_en & (i_rd_addr == HI_ADDR);
        assign lo_ok       = seen_lo_q | rd_lo[g];
        assign hi_ok       = seen_hi_q | rd_hi[g];
        // Status reads before the event read do not count [R5] [R8] [R11]
        assign grp_done[g] = (state_q == MSI_CLR_ARMED) & lo_ok & hi_ok;

        always_comb begin
            case (state_q)
                MSI_CLR_IDLE:  state_d = rd_event ? MSI_CLR_ARMED
                                                  : MSI_CLR_IDLE;
                MSI_CLR_ARMED: state_d = grp_done[g] ? MSI_CLR_IDLE
                                                     : MSI_CLR_ARMED;
                default:       state_d = MSI_CLR_IDLE;
            endcase
        end

        always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                state_q   <= MSI_CLR_IDLE;
                seen_lo_q <= 1'b0;
                seen_hi_q <= 1'b0;
            end else begin
                state_q   <= rd_event ? MSI_CLR_ARMED : state_d;
                seen_lo_q <= !rd_event && !grp_done[g]
                             && (state_q == MSI_CLR_ARMED) && lo_ok;
                seen_hi_q <= !rd_event && !grp_done[g]
                             && (state_q == MSI_CLR_ARMED) && hi_ok;
            end
        end
    end

    // ************************************************************
    // ADC refresh, averaging and overrun per port
    // ************************************************************
    logic [PORTS-1:0] adc_overwrite;
    logic [PORTS-1:0] adc_status;

    for (genvar p = 0; p < PORTS; p++) begin : g_adc
        logic [AVG_W-1:0] avg;
        logic [CNT_W-1:0] target;
        logic [CNT_W-1:0] cnt_q;
        logic             pending_q;
        logic             unread_q;
        logic             status_q;
        logic             trig;
        logic             single;

        assign avg    = i_adc_avg_log2[p*AVG_W +: AVG_W];
        // 2^N samples, counted from zero
        assign target = CNT_W'((8'h01 << avg) - 8'h01);
        assign single = (i_adc_mode == MSI_ADC_SINGLE_CONV);
        // One sample per conversion or per finished sweep [R4]
        assign trig   = single ? i_adc_conv_done[p]
                               : (i_adc_sweep_done
                                  & (pending_q | i_adc_conv_done[p]));
        assign o_adc_refresh[p] = trig & (cnt_q == target); // [R3]
        assign adc_overwrite[p] = o_adc_refresh[p] & unread_q; // [R6]
        assign adc_status[p]    = status_q;

        always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                cnt_q     <= CNT_RESET;
                pending_q <= 1'b0;
                unread_q  <= 1'b0;
                status_q  <= 1'b0;
            end else begin
                if (trig) begin
                    cnt_q <= (cnt_q == target) ? CNT_RESET
                                               : cnt_q + 7'h01; // [R3]
                end
                pending_q <= !single && !i_adc_sweep_done
                             && (pending_q || i_adc_conv_done[p]);
                unread_q  <= o_adc_refresh[p]
                             | (unread_q & ~i_adc_data_read[p]);
                // Captured with no mask in the path [R16]
                status_q  <= o_adc_refresh[p]
                             | (status_q & ~grp_done[GRP_ADC]);
            end
        end

        property p_avg_refresh;
            @(posedge i_ref_clk) disable iff (!i_reset_n)
            o_adc_refresh[p] |-> trig && cnt_q == target;
        endproperty
        a_avg_refresh: assert property (p_avg_refresh) // [R3]
            else $error("ADC refresh before averaging complete");
    end

    // ************************************************************
    // Input event capture per port
    // ************************************************************
    logic [PORTS-1:0] in_hit;
    logic [PORTS-1:0] in_status_q;

    for (genvar p = 0; p < PORTS; p++) begin : g_in
        msi_in_mode_t mode;
        logic         rise;
        logic         fall;

        assign mode      = msi_in_mode_t'(i_in_mode[2*p +: 2]);
        assign rise      = in_s[p] & ~in_prev_q[p];
        assign fall      = ~in_s[p] & in_prev_q[p];
        assign in_hit[p] = ((mode == MSI_IN_RISE) & rise)
                         | ((mode == MSI_IN_FALL) & fall)
                         | ((mode == MSI_IN_BOTH) & (rise | fall)); // [R7]
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            in_prev_q   <= '0;
            in_status_q <= '0;
        end else begin
            in_prev_q   <= in_s;
            // Set wins over the sequence clear [R16]
            in_status_q <= in_hit | (in_status_q & ~{PORTS{grp_done[GRP_IN]}});
        end
    end

    // ************************************************************
    // Overcurrent status
    // ************************************************************
    logic [PORTS-1:0] oc_status_q;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            oc_status_q <= '0;
        end else begin
            // A lasting fault keeps the status set through the clear
            oc_status_q <= oc_s
                         | (oc_status_q & ~{PORTS{grp_done[GRP_OC]}}); // [R10]
        end
    end

    assign grp_status[GRP_ADC] = adc_status;
    assign grp_status[GRP_IN]  = in_status_q;
    assign grp_status[GRP_OC]  = oc_status_q;

    // ************************************************************
    // Event register
    // ************************************************************
    logic [5:0]  flags_set;
    logic [5:0]  flags_clr;
    logic [5:0]  flags_q;
    logic        supply_q;
    logic [2:0]  temp_int;
    logic [2:0]  temp_rem1;
    logic [2:0]  temp_rem2;
    logic [15:0] event_value;

    assign flags_set[BIT_ADC_GENERAL] = i_adc_flag_event;          // [R17]
    assign flags_set[BIT_ADC_READY]   = |o_adc_refresh;            // [R2]
    assign flags_set[BIT_ADC_OVERRUN] = |adc_overwrite;            // [R6]
    assign flags_set[BIT_IN_EVENT]    = |in_hit;                   // [R7]
    assign flags_set[BIT_IN_OVERRUN]  = |(in_hit & in_status_q);   // [R9]
    assign flags_set[BIT_OVERCURRENT] = |oc_s;                     // [R10]

    assign flags_clr[BIT_ADC_GENERAL] = rd_event;                  // [R17]
    assign flags_clr[BIT_ADC_READY]   = grp_done[GRP_ADC];         // [R5]
    assign flags_clr[BIT_ADC_OVERRUN] = rd_event;                  // [R6]
    assign flags_clr[BIT_IN_EVENT]    = grp_done[GRP_IN];          // [R8]
    assign flags_clr[BIT_IN_OVERRUN]  = grp_done[GRP_IN];          // [R8]
    assign flags_clr[BIT_OVERCURRENT] = grp_done[GRP_OC];          // [R11]

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags_q  <= 6'h00;
            supply_q <= 1'b0;
        end else begin
            // An event in the clearing cycle is kept
            flags_q  <= flags_set | (flags_q & ~flags_clr);
            supply_q <= supply_low_s | (supply_q & ~rd_event); // [R15]
        end
    end

    msi_temp_flags u_temp_int (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_temp    (i_temp_int),
        .i_clear   (rd_event),
        .o_flags   (temp_int)
    );

    msi_temp_flags u_temp_rem1 (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_temp    (i_temp_rem1),
        .i_clear   (rd_event),
        .o_flags   (temp_rem1)
    );

    msi_temp_flags u_temp_rem2 (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_temp    (i_temp_rem2),
        .i_clear   (rd_event),
        .o_flags   (temp_rem2)
    );

    assign event_value = {supply_q, temp_rem2, temp_rem1, temp_int, flags_q};

    // ************************************************************
    // Read data
    // ************************************************************
    logic [15:0] rd_data_d;

    assign rd_data_d =
        rd_id    ? DEVICE_IDENTITY_CODE :                           // [R1]
        rd_event ? event_value :
        rd_lo[0] ? {5'h00, grp_status[0][STATUS_LO_W-1:0]} :
        rd_hi[0] ? {15'h0000, grp_status[0][STATUS_HI_BIT]} :
        rd_lo[1] ? {5'h00, grp_status[1][STATUS_LO_W-1:0]} :
        rd_hi[1] ? {15'h0000, grp_status[1][STATUS_HI_BIT]} :
        rd_lo[2] ? {5'h00, grp_status[2][STATUS_LO_W-1:0]} :
        rd_hi[2] ? {15'h0000, grp_status[2][STATUS_HI_BIT]} :
        READ_IDLE;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data  <= READ_IDLE;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_data  <= rd_data_d;
            o_rd_valid <= i_rd_en;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_identity;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        rd_id |=> o_rd_valid && o_rd_data == DEVICE_IDENTITY_CODE;
    endproperty
    a_identity: assert property (p_identity) // [R1]
        else $error("identity read returned wrong value");

    property p_ready_set;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        |o_adc_refresh |=> flags_q[BIT_ADC_READY];
    endproperty
    a_ready_set: assert property (p_ready_set) // [R2]
        else $error("ready flag not set on refresh");

    property p_single_conv;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_adc_mode == MSI_ADC_SINGLE_CONV) && i_adc_conv_done[0]
        && i_adc_avg_log2[AVG_W-1:0] == 3'h0 |-> o_adc_refresh[0];
    endproperty
    a_single_conv: assert property (p_single_conv) // [R4]
        else $error("single conversion did not refresh");

    property p_ready_hold;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        flags_q[BIT_ADC_READY] && !grp_done[GRP_ADC]
        |=> flags_q[BIT_ADC_READY];
    endproperty
    a_ready_hold: assert property (p_ready_hold) // [R5]
        else $error("ready flag cleared without status reads");

    property p_overrun;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        flags_q[BIT_ADC_OVERRUN] && rd_event && !(|adc_overwrite)
        |=> !flags_q[BIT_ADC_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun) // [R6]
        else $error("overrun flag not cleared by event read");

    property p_in_clear;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        rd_event ##1 !rd_event ##1 !rd_event ##1 rd_hi[GRP_IN]
        ##1 !rd_event ##1 !rd_event ##1 (rd_lo[GRP_IN] && !(|in_hit))
        |=> !flags_q[BIT_IN_EVENT] && !flags_q[BIT_IN_OVERRUN];
    endproperty
    a_in_clear: assert property (p_in_clear) // [R8]
        else $error("input flags not cleared after sequence");

    property p_oc_set;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(|oc_s) |=> flags_q[BIT_OVERCURRENT];
    endproperty
    a_oc_set: assert property (p_oc_set) // [R10]
        else $error("overcurrent flag not set");

    property p_supply;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        supply_low_s |=> event_value[BIT_SUPPLY_LOW];
    endproperty
    a_supply: assert property (p_supply) // [R15]
        else $error("supply low flag not set");

endmodule

// ### msi_host_model.sv
// Host side register reader for the event flag block
`timescale 1ns/1ps
module msi_host_model
    import msi_pkg::*;
(
    input  wire logic        i_ref_clk,  // System clock
    input  wire logic [15:0] i_rd_data,  // Read data from block
    input  wire logic        i_rd_valid, // Read data strobe
    output logic             o_rd_en,    // Read request
    output logic [7:0]       o_rd_addr   // Read address
);
    initial begin
        o_rd_en   = 1'b0;
        o_rd_addr = 8'hFF;
    end

    // One-cycle request; a released address shows its inverse
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d,
                            output logic v);
        @(posedge i_ref_clk);
        o_rd_en   <= 1'b1;
        o_rd_addr <= a;
        @(posedge i_ref_clk);
        o_rd_en   <= 1'b0;
        o_rd_addr <= ~a;
        // Answer stands for the cycle after the request edge
        @(posedge i_ref_clk);
        d = i_rd_data;
        v = i_rd_valid;
    endtask
endmodule

// ### msi_event_flags_tb.sv
// Self-checking bench for the event flag block
`timescale 1ns/1ps
module msi_event_flags_tb
    import msi_pkg::*;
;
    logic clk, rst_n, sweep, gflag, vlow, rd_en, rd_valid;
    logic [7:0] rd_addr;
    logic [15:0] rd_data;
    logic [PORTS-1:0] conv, dread, in_pin, oc, refresh;
    logic [PORTS*AVG_W-1:0] avg;
    logic [PORTS*2-1:0] in_mode;
    msi_adc_mode_t adc_mode;
    msi_temp_t t_int, t_r1, t_r2;
    int failures, checked, cycles, refreshes;

    msi_event_flags dut (.i_ref_clk(clk), .i_reset_n(rst_n),
        .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .i_adc_mode(adc_mode),
        .i_adc_conv_done(conv), .i_adc_sweep_done(sweep),
        .i_adc_avg_log2(avg), .i_adc_data_read(dread),
        .i_adc_flag_event(gflag), .o_adc_refresh(refresh), .i_in_pin(in_pin),
        .i_in_mode(in_mode), .i_oc_pin(oc), .i_supply_low_pin(vlow),
        .i_temp_int(t_int), .i_temp_rem1(t_r1), .i_temp_rem2(t_r2));

    msi_host_model u_host (.i_ref_clk(clk), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid), .o_rd_en(rd_en), .o_rd_addr(rd_addr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run();
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard, far above the about 155 cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            complete_run();
        end
    end

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        u_host.read_reg(a, d, v);
        checked = checked + 1;
        if (v !== 1'b1 || d !== exp) begin
            failures = failures + 1;
            $display("ERROR reg %h expected %h seen %h", a, exp, d);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk_count(input int exp, input int seen);
        checked = checked + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR refresh count expected %0d seen %0d", exp,
                     seen);
        end
    endtask

    // No two ports refresh in the same cycle in these tests
    always @(posedge clk) begin
        if (|refresh) refreshes <= refreshes + 1;
    end

    initial begin
        {failures, checked, cycles, refreshes} = '0;
        {rst_n, sweep, gflag, vlow, conv, dread, in_pin, oc, avg} = '0;
        in_mode  = '0;
        adc_mode = MSI_ADC_SINGLE_CONV;
        t_int = '{1'b0, 12'h100, 12'h0F0, 12'h000};
        t_r1  = '{1'b0, 12'hF00, 12'h100, 12'h000};
        t_r2  = '{1'b0, 12'h050, 12'h100, 12'h000};
        wait_clk(10);
        rst_n <= 1'b1;
        rd(ADDR_IDENTITY, DEVICE_IDENTITY_CODE);
        rd(ADDR_EVENT, 16'h0000);
        rd(8'h10, READ_IDLE);
        // Supply dip then recovery; flag must stick
        vlow <= 1'b1;
        wait_clk(6);
        vlow <= 1'b0;
        wait_clk(6);
        rd(ADDR_EVENT, 16'h8000);
        rd(ADDR_EVENT, 16'h0000);
        // Above high, below low, in range
        {t_int.valid, t_r1.valid, t_r2.valid, gflag} <= 4'hF;
        wait_clk(1);
        {t_int.valid, t_r1.valid, t_r2.valid, gflag} <= 4'h0;
        wait_clk(2);
        rd(ADDR_EVENT, 16'h1741);
        rd(ADDR_EVENT, 16'h0000);
        // Two unread samples on port 0 overrun it
        repeat (2) begin
            conv[0] <= 1'b1;
            wait_clk(1);
            conv[0] <= 1'b0;
            wait_clk(1);
        end
        wait_clk(2);
        rd(ADDR_EVENT, 16'h0006);
        // Data read first, so the next sample is no overrun
        dread[0] <= 1'b1;
        wait_clk(1);
        {dread[0], conv[0]} <= 2'h1;
        wait_clk(1);
        conv[0] <= 1'b0;
        wait_clk(1);
        rd(ADDR_EVENT, 16'h0002);
        rd(ADDR_STATUS_BASE, 16'h0001);
        rd(8'h03, 16'h0000);
        rd(ADDR_EVENT, 16'h0000);
        // Port 5 averages two sweeps
        adc_mode <= MSI_ADC_CONT_SWEEP;
        avg[17:15] <= 3'h1;
        for (int i = 0; i < 2; i++) begin
            conv[5] <= 1'b1;
            wait_clk(1);
            {conv[5], sweep} <= 2'b01;
            wait_clk(1);
            sweep <= 1'b0;
            wait_clk(2);
            rd(ADDR_EVENT, {14'h0, i[0], 1'b0});
        end
        // Port 11 rises twice and overruns; port 10 takes both edges
        in_mode[23:20] <= {2'(MSI_IN_RISE), 2'(MSI_IN_BOTH)};
        wait_clk(4);
        repeat (2) begin
            in_pin[11:10] <= 2'h3;
            wait_clk(6);
            in_pin[11:10] <= 2'h0;
            wait_clk(6);
        end
        rd(ADDR_EVENT, 16'h001A);
        rd(8'h05, 16'h0001);
        rd(8'h04, 16'h0400);
        rd(8'h02, 16'h0020);
        rd(8'h03, 16'h0000);
        rd(ADDR_EVENT, 16'h0000);
        // Overcurrent pulse on port 0
        oc[0] <= 1'b1;
        wait_clk(6);
        oc[0] <= 1'b0;
        wait_clk(6);
        rd(ADDR_EVENT, 16'h0020);
        rd(8'h06, 16'h0001);
        rd(8'h07, 16'h0000);
        rd(ADDR_EVENT, 16'h0000);
        chk_count(4, refreshes);
        complete_run();
    end
endmodule
